/* File: sim/biec_irq_partner.sv */
// Far-side interrupt pins that feed the bridge
`timescale 1ns/100ps
module biec_irq_partner (
    input wire logic i_clk,
    input wire logic [3:0] i_raise,
    output logic [3:0] o_pin_irq
);
    // Pins move a few ns after an edge, unrelated to the sampling moment
    initial o_pin_irq = 4'h0;
    always @(posedge i_clk) o_pin_irq <= #3 i_raise;
endmodule : biec_irq_partner

/* File: sim/biec_props.sv */
// Concurrent checks on the ports of the interrupt enable block
`timescale 1ns/100ps
module biec_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_addr,
    input wire biec_pkg::biec_word_t i_reg_wdata,
    input wire biec_pkg::biec_word_t o_reg_rdata,
    input wire logic o_reg_ack,
    input wire logic [3:0] i_pin_irq,
    input wire logic i_outbound_post_mask,
    input wire logic [4:0] i_queue_level,
    input wire logic o_pci_irq,
    input wire logic o_local_irq
);
    import biec_pkg::*;
    // Shadow of the written enables; long antecedents hide the pin synchroniser delay
    biec_word_t en;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) en <= 32'h0;
        else if (i_reg_wr && i_reg_addr == 12'h604) en <= i_reg_wdata;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_ack; (i_reg_rd || i_reg_wr) |=> o_reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");
    property p_unmapped; (i_reg_rd && !i_reg_wr && i_reg_addr[11:8] != 4'h6) |=> o_reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctl_read; (i_reg_rd && !i_reg_wr && i_reg_addr == 12'h604) |=> o_reg_rdata[7:0] == 8'h00 && o_reg_rdata[13] == $past(i_outbound_post_mask); endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("enable read bits wrong");
    property p_local_pass; (en[23] && i_pin_irq[3]) [*8] |-> o_local_irq; endproperty
    a_local_pass: assert property (p_local_pass) else $error("pci pin not passed");
    property p_pci_pass; (en[20] && i_pin_irq[0]) [*8] |-> o_pci_irq; endproperty
    a_pci_pass: assert property (p_pci_pass) else $error("local pin not passed");
    property p_gate_off; (en == 32'h0 && !i_outbound_post_mask) [*3] |-> !o_pci_irq && !o_local_irq; endproperty
    a_gate_off: assert property (p_gate_off) else $error("irq with all enables off");
    property p_queue; (en[11] && i_queue_level[3]) [*3] |-> o_local_irq; endproperty
    a_queue: assert property (p_queue) else $error("free empty irq missing");
    property p_mirror; (i_outbound_post_mask && i_queue_level[4]) [*3] |-> o_pci_irq; endproperty
    a_mirror: assert property (p_mirror) else $error("not empty irq missing");
endmodule : biec_props
bind biec_top biec_props biec_props_inst (.i_clk, .i_rst, .i_reg_rd, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .i_pin_irq, .i_outbound_post_mask, .i_queue_level,
    .o_pci_irq, .o_local_irq);

/* File: sim/tb_top.sv */
// Self-checking bench for the interrupt enable block
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
    import biec_pkg::*;
    int fails = 0;
    int num_checks = 0;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_reg_rd = 1'b0;
    logic i_reg_wr = 1'b0;
    logic [11:0] i_reg_addr = 12'h000;
    biec_word_t i_reg_wdata = 32'h0;
    biec_word_t i_src_event = 32'h0;
    logic i_outbound_post_mask = 1'b0;
    logic i_inbound_new_entry = 1'b0;
    logic [4:0] i_queue_level = 5'h0c;
    logic [3:0] raise = 4'h0;
    logic [3:0] i_pin_irq;
    biec_word_t o_reg_rdata;
    biec_word_t d;
    logic o_reg_ack, o_pci_irq, o_local_irq;
    always #20 i_clk = ~i_clk;
    biec_top biec_top_inst (.i_clk, .i_rst, .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_ack, .i_src_event, .i_pin_irq, .i_outbound_post_mask,
        .i_inbound_new_entry, .i_queue_level, .o_pci_irq, .o_local_irq);
    biec_irq_partner biec_irq_partner_inst (.i_clk(i_clk), .i_raise(raise), .o_pin_irq(i_pin_irq));
    // ----
    // Shared steps
    // ----
    task automatic xfer(input logic w, input logic [11:0] a, input biec_word_t v);
        @(posedge i_clk);
        i_reg_wr <= w;
        i_reg_rd <= !w;
        i_reg_addr <= a;
        i_reg_wdata <= v;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
        `CHK("ack", 1'b1, o_reg_ack)
    endtask : xfer
    task automatic rc(input logic [11:0] a, input biec_word_t e);
        xfer(1'b0, a, 32'h0);
        `CHK("rdata", e, d)
    endtask : rc
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic irq(input logic p, input logic l);
        `CHK("pci irq", p, o_pci_irq)
        `CHK("local irq", l, o_local_irq)
    endtask : irq
    task automatic ev(input biec_word_t e, input logic n);
        @(posedge i_clk);
        i_src_event <= e;
        i_inbound_new_entry <= n;
        @(posedge i_clk);
        i_src_event <= 32'h0;
        i_inbound_new_entry <= 1'b0;
    endtask : ev
    task automatic clr();
        xfer(1'b1, 12'h604, 32'h0);
        xfer(1'b1, 12'h600, 32'hffff_ffff);
    endtask : clr
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rc(12'h604, 32'h0);
        rc(12'h600, 32'h0000_0c00);
        rc(12'h700, 32'h0);
        rc(12'h608, 32'h0010_2000);
        i_queue_level <= 5'h00;
    endtask : t_reset
    task automatic t_rst_mid();
        xfer(1'b1, 12'h604, 32'hffff_ffff);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rc(12'h604, 32'h0);
        tick(2);
        irq(1'b0, 1'b0);
    endtask : t_rst_mid
    task automatic t_rw();
        xfer(1'b1, 12'h604, 32'hffff_ffff);
        rc(12'h604, 32'hffff_df00);
        i_outbound_post_mask <= 1'b1;
        rc(12'h604, 32'hffff_ff00);
        i_outbound_post_mask <= 1'b0;
        rc(12'h600, 32'h0000_0003);
        clr();
        rc(12'h600, 32'h0);
    endtask : t_rw
    task automatic t_events();
        for (int b = 14; b < 32; b++) begin
            if (b < 20 || b > 23) begin
                clr();
                ev(32'h1 << b, 1'b0);
                tick(3);
                irq(1'b0, 1'b0);
                xfer(1'b1, 12'h604, 32'h1 << b);
                ev(32'h1 << b, 1'b0);
                tick(3);
                irq(1'b0, 1'b1);
            end
        end
        xfer(1'b1, 12'h608, 32'h8000_0000);
        tick(2);
        irq(1'b1, 1'b0);
        xfer(1'b1, 12'h608, 32'h0);
    endtask : t_events
    task automatic t_pins();
        for (int p = 0; p < 4; p++) begin
            clr();
            raise <= 4'h1 << p;
            tick(8);
            irq(1'b0, 1'b0);
            xfer(1'b1, 12'h604, 32'h1 << (20 + p));
            tick(8);
            irq(p == 0, p != 0);
            raise <= 4'h0;
        end
    endtask : t_pins
    task automatic t_queue();
        for (int q = 0; q < 4; q++) begin
            clr();
            xfer(1'b1, 12'h604, 32'h100 << q);
            i_queue_level <= 5'h1 << q;
            tick(3);
            irq(1'b0, 1'b1);
            i_queue_level <= 5'h00;
            tick(3);
            irq(1'b0, 1'b0);
        end
        clr();
        i_outbound_post_mask <= 1'b1;
        i_queue_level <= 5'h10;
        tick(3);
        irq(1'b1, 1'b0);
        i_outbound_post_mask <= 1'b0;
        i_queue_level <= 5'h00;
        clr();
        ev(32'h0, 1'b1);
        rc(12'h600, 32'h0);
        xfer(1'b1, 12'h604, 32'h1000);
        ev(32'h0, 1'b1);
        tick(2);
        irq(1'b0, 1'b1);
        rc(12'h600, 32'h1000);
    endtask : t_queue
    task automatic end_sim();
        if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_rw();
        t_events();
        t_pins();
        t_queue();
        t_rst_mid();
        end_sim();
    end
    // Whole run needs a few hundred cycles; this is ten thousand
    initial begin
        #400000;
        fails++;
        end_sim();
    end
endmodule : tb_top

/* File: src/biec_defines.svh */
// Offsets, field positions, reset values and direction constants of the interrupt enable block
`ifndef BIEC_DEFINES_SVH
`define BIEC_DEFINES_SVH

`define BIEC_STAT_OFFSET 12'h600
`define BIEC_CTL_OFFSET 12'h604
`define BIEC_DIR_OFFSET 12'h608

`define BIEC_SRC_COUNT 32
`define BIEC_CTL_RESET 32'h0000_0000
`define BIEC_WR_MASK 32'hffff_df00
`define BIEC_FIXED_DIR_ONE 32'h0010_2000
`define BIEC_FIXED_DIR_ZERO 32'h00e0_5000
`define BIEC_QUEUE_LEVEL_MASK 32'h0000_2f00
`define BIEC_STAT_RESET 32'h0000_0c00

`define BIEC_BIT_PCI_PASS 23
`define BIEC_BIT_PARITY_PASS 22
`define BIEC_BIT_SYSERR_PASS 21
`define BIEC_BIT_LOCAL_PASS 20
`define BIEC_BIT_OUT_NOT_EMPTY 13
`define BIEC_BIT_IN_NEW_ENTRY 12
`define BIEC_BIT_SW1 1
`define BIEC_BIT_SW0 0

`endif

/* File: src/biec_pkg.sv */
// Types shared by the interrupt enable block
package biec_pkg;
    typedef logic [31:0] biec_word_t;
    typedef enum logic [1:0] {
        BIEC_ACC_IDLE,
        BIEC_ACC_READ,
        BIEC_ACC_WRITE
    } biec_acc_t;
endpackage : biec_pkg

/* File: src/biec_route_if.sv */
// Bundle of interrupt sources, their gates and their directions
`timescale 1ns/100ps
interface biec_route_if;
    import biec_pkg::*;
    biec_word_t pending;
    biec_word_t enable;
    biec_word_t direction;
    logic pci_irq;
    logic local_irq;
    modport ctl (output pending, output enable, output direction, input pci_irq, input local_irq);
    modport route (input pending, input enable, input direction, output pci_irq, output local_irq);
endinterface : biec_route_if

/* File: src/biec_router.sv */
// Gates each pending source with its enable and steers it by its direction
`timescale 1ns/100ps
module biec_router (
    biec_route_if.route rt
);
    import biec_pkg::*;

    biec_word_t gated;

    assign gated = rt.pending & rt.enable;
    assign rt.pci_irq = |(gated & rt.direction);
    assign rt.local_irq = |(gated & ~rt.direction);
endmodule : biec_router

/* File: src/biec_sync.sv */
// Three-stage synchroniser bank; a change counts once stages two and three agree
`timescale 1ns/100ps
module biec_sync #(
    parameter int WIDTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    meta[g] <= 1'b0;
                    s2[g] <= 1'b0;
                    s3[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta[g] <= i_async[g];
                    s2[g] <= meta[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        o_sync[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate
endmodule : biec_sync

/* File: src/biec_top.sv */
// Interrupt enable control of the bridge: register channel, status bits and routing
`timescale 1ns/100ps
`include "biec_defines.svh"
module biec_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [11:0] i_reg_addr,
    input wire biec_pkg::biec_word_t i_reg_wdata,
    output biec_pkg::biec_word_t o_reg_rdata,
    output logic o_reg_ack,
    input wire biec_pkg::biec_word_t i_src_event,
    input wire logic [3:0] i_pin_irq,
    input wire logic i_outbound_post_mask,
    input wire logic i_inbound_new_entry,
    input wire logic [4:0] i_queue_level,
    output logic o_pci_irq,
    output logic o_local_irq
);
    import biec_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    biec_word_t ctl;
    biec_word_t status;
    biec_word_t direction;
    biec_word_t next_status;
    biec_word_t set_event;
    biec_word_t level_src;
    biec_word_t ctl_view;
    biec_word_t dir_view;
    biec_word_t read_mux;
    biec_acc_t access;
    logic [3:0] pins;
    logic hit_stat;
    logic hit_ctl;
    logic hit_dir;
    logic rt_pci;
    logic rt_local;

    biec_route_if rt ();

    // ----------------------------------------------------------------
    // Pin inputs cross in through four flops
    // ----------------------------------------------------------------
    // pins: 3 pci irq, 2 parity error, 1 system error, 0 local irq
    biec_sync #(.WIDTH(4)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(i_pin_irq),
        .o_sync(pins)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign hit_stat = (i_reg_addr == `BIEC_STAT_OFFSET);
    assign hit_ctl = (i_reg_addr == `BIEC_CTL_OFFSET);
    assign hit_dir = (i_reg_addr == `BIEC_DIR_OFFSET);
    assign access = i_reg_wr ? BIEC_ACC_WRITE : (i_reg_rd ? BIEC_ACC_READ : BIEC_ACC_IDLE);

    // Enable view: mirror bit and zero-reading trigger bits folded in
    always_comb begin
        ctl_view = ctl;
        ctl_view[`BIEC_BIT_OUT_NOT_EMPTY] = i_outbound_post_mask;
        ctl_view[`BIEC_BIT_SW1] = 1'b0;
        ctl_view[`BIEC_BIT_SW0] = 1'b0;
    end

    assign dir_view = (direction & ~`BIEC_FIXED_DIR_ZERO) | `BIEC_FIXED_DIR_ONE;

    assign read_mux = hit_stat ? status : (hit_ctl ? ctl_view : (hit_dir ? dir_view : '0));

    // ----------------------------------------------------------------
    // Status events
    // ----------------------------------------------------------------
    // Queue levels follow their sources whatever the enables say
    always_comb begin
        level_src = '0;
        level_src[15] = 1'b0;
        level_src[13] = i_queue_level[4];
        level_src[11:8] = i_queue_level[3:0];
    end

    always_comb begin
        set_event = i_src_event & ~`BIEC_QUEUE_LEVEL_MASK;
        set_event[`BIEC_BIT_PCI_PASS] = pins[3];
        set_event[`BIEC_BIT_PARITY_PASS] = pins[2];
        set_event[`BIEC_BIT_SYSERR_PASS] = pins[1];
        set_event[`BIEC_BIT_LOCAL_PASS] = pins[0];
        // Only counted while enabled, so a stale post does not fire later
        set_event[`BIEC_BIT_IN_NEW_ENTRY] = i_inbound_new_entry & ctl[`BIEC_BIT_IN_NEW_ENTRY];
        set_event[`BIEC_BIT_SW1] = (access == BIEC_ACC_WRITE) & hit_ctl
            & i_reg_wdata[`BIEC_BIT_SW1];
        set_event[`BIEC_BIT_SW0] = (access == BIEC_ACC_WRITE) & hit_ctl
            & i_reg_wdata[`BIEC_BIT_SW0];
        set_event[7:2] = 6'h00;
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_comb begin
        next_status = status;
        if ((access == BIEC_ACC_WRITE) && hit_stat) begin
            next_status = status & ~i_reg_wdata;
        end
        next_status = (next_status | set_event) & ~`BIEC_QUEUE_LEVEL_MASK;
        next_status = next_status | level_src;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl <= `BIEC_CTL_RESET;
        end else if ((access == BIEC_ACC_WRITE) && hit_ctl) begin
            ctl <= i_reg_wdata & `BIEC_WR_MASK;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            direction <= '0;
        end else if ((access == BIEC_ACC_WRITE) && hit_dir) begin
            direction <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status <= `BIEC_STAT_RESET;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
            o_reg_ack <= 1'b0;
        end else begin
            o_reg_ack <= (access != BIEC_ACC_IDLE);
            o_reg_rdata <= (access == BIEC_ACC_READ) ? read_mux : '0;
        end
    end

    // ----------------------------------------------------------------
    // Routing
    // ----------------------------------------------------------------
    // Enables gate every source
    assign rt.pending = status;
    assign rt.enable = ctl_view;
    assign rt.direction = dir_view;
    assign rt_pci = rt.pci_irq;
    assign rt_local = rt.local_irq;

    biec_router u_router (
        .rt(rt)
    );

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pci_irq <= 1'b0;
            o_local_irq <= 1'b0;
        end else begin
            o_pci_irq <= rt_pci;
            o_local_irq <= rt_local;
        end
    end
endmodule : biec_top
